//--- hdl/adcrc_pkg.sv
// Purpose: Shared constants and types for the converter result, compare and delay block
// Assumes: Register indices sit on word addresses (byte address = 4 * index)
// Notes:   Result, threshold and delay widths are fixed by the register layout
package adcrc_pkg;
    // Register indices on the bus
    localparam logic [7:0] ADCRC_IDX_RES_LO  = 8'hC2; // Result bits 3..0
    localparam logic [7:0] ADCRC_IDX_RES_HI  = 8'hC3; // Result bits 11..4
    localparam logic [7:0] ADCRC_IDX_CMP_LO  = 8'hCE; // Threshold bits 3..0
    localparam logic [7:0] ADCRC_IDX_CMP_HI  = 8'hCF; // Threshold bits 11..4
    localparam logic [7:0] ADCRC_IDX_CTL0    = 8'hE8; // Done flag and busy/start
    localparam logic [7:0] ADCRC_IDX_CTL1    = 8'hE1; // External select, enable
    localparam logic [7:0] ADCRC_IDX_CTL2    = 8'hE2; // Compare control, delay bit 8
    localparam logic [7:0] ADCRC_IDX_DLY     = 8'hE3; // Delay bits 7..0
    localparam logic [7:0] ADCRC_IDX_AOFF    = 8'hF6; // Pin digital input off
    localparam logic [7:0] ADCRC_IDX_PWM     = 8'hD0; // PWM run bit
    localparam logic [7:0] ADCRC_IDX_IRQ_ST  = 8'hD1; // Sticky event status, read only
    localparam logic [7:0] ADCRC_IDX_IRQ_CLR = 8'hD2; // Write one to clear status
    localparam logic [7:0] ADCRC_IDX_IRQ_EN  = 8'hD3; // Event enables

    // Field positions
    localparam int ADCRC_CTL0_DONE = 7; // Conversion done flag
    localparam int ADCRC_CTL0_BUSY = 6; // Busy on read, start on write
    localparam int ADCRC_CTL1_EXT  = 1; // External trigger select
    localparam int ADCRC_CTL1_EN   = 0; // Converter enable
    localparam int ADCRC_EV_DONE   = 0; // Event: conversion done
    localparam int ADCRC_EV_BRAKE  = 1; // Event: compare fault brake

    // Widths and reset values
    localparam int         ADCRC_RES_W   = 12;
    localparam int         ADCRC_DLY_W   = 9;
    localparam int         ADCRC_EV_N    = 2;
    localparam logic [7:0] ADCRC_RST_BYTE = 8'h00;
    // Converter clock divider: system clocks per converter clock period
    localparam int         ADCRC_ADC_DIV = 4;

    // Second control register layout
    typedef struct packed {
        logic       brake_on_compare_en; // Compare result forces fault brake
        logic       compare_polarity;    // 0: result >= threshold, 1: result < threshold
        logic       comparator_en;       // Comparator evaluates results
        logic       compare_result_flag; // Read only
        logic [2:0] rsvd;                // Read as zero
        logic       dly_bit8;            // Trigger delay count bit 8
    } adcrc_ctl2_t;

    // Conversion sequencer states, Gray along idle -> delay -> convert
    typedef enum logic [1:0] {
        ADCRC_IDLE  = 2'b00,
        ADCRC_DELAY = 2'b01,
        ADCRC_CONV  = 2'b11
    } adcrc_state_t;
endpackage

//--- hdl/adcrc_delay.sv
// Purpose: Counts the external trigger delay in converter clock periods
// Assumes: tick is a one-cycle pulse per converter clock period
// Notes:   A count of zero fires on the cycle after go
module adcrc_delay
    import adcrc_pkg::*;
#(
    parameter int W = ADCRC_DLY_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         go,    // Accepted external trigger
    input  wire logic         tick,  // Converter clock enable
    input  wire logic [W-1:0] count, // Programmed delay
    output logic              fire   // One-cycle pulse when delay ends
);
    typedef enum logic {ADCRC_D_IDLE = 1'b0, ADCRC_D_RUN = 1'b1} adcrc_dstate_t;

    adcrc_dstate_t  st_reg,  st_next;  // Counter state
    logic [W-1:0]   cnt_reg, cnt_next; // Remaining periods
    logic           fire_reg, fire_next;

    // Next-state logic
    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        fire_next = 1'b0;
        case (st_reg)
            ADCRC_D_IDLE: begin
                if (go) begin
                    if (count == '0) begin
                        fire_next = 1'b1; // No delay programmed
                    end else begin
                        cnt_next = count;
                        st_next  = ADCRC_D_RUN;
                    end
                end
            end
            ADCRC_D_RUN: begin
                if (tick) begin
                    cnt_next = cnt_reg - 1'b1;
                    if (cnt_reg == {{(W-1){1'b0}}, 1'b1}) begin
                        fire_next = 1'b1; // Last period elapsed [RULE7]
                        st_next   = ADCRC_D_IDLE;
                    end
                end
            end
            default: st_next = ADCRC_D_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg   <= ADCRC_D_IDLE;
            cnt_reg  <= '0;
            fire_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            fire_reg <= fire_next;
        end
    end

    assign fire = fire_reg;

    AST_DLY_ZERO: assert property (@(posedge clk) disable iff (rst)
        (st_reg == ADCRC_D_IDLE && go && count == '0) |=> fire) // [RULE7]
        else $error("Zero delay did not fire at once");
endmodule

//--- hdl/adcrc_compare.sv
// Purpose: Result comparator, compare flag and fault brake latch
// Assumes: load marks the cycle the new result is written
// Notes:   Flag and brake update on the load edge itself, from the incoming result
module adcrc_compare
    import adcrc_pkg::*;
#(
    parameter int W = ADCRC_RES_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,      // New result arrives
    input  wire logic [W-1:0] result,    // Incoming result
    input  wire logic [W-1:0] threshold, // Compare threshold
    input  wire logic         polarity,  // 0: >=, 1: <
    input  wire logic         enable,    // Comparator enable
    input  wire logic         brake_en,  // Brake on compare
    input  wire logic         run_set,   // Software sets PWM run again
    output logic              hit,       // Brake trigger this cycle
    output logic              flag,      // Compare result flag
    output logic              brake      // Fault brake level
);
    logic flag_reg,  flag_next;
    logic brake_reg, brake_next;
    logic cmp;

    // Comparison with selectable polarity
    always_comb begin
        cmp = polarity ? (result < threshold) : (result >= threshold); // [RULE3]
        flag_next  = flag_reg;
        if (load && enable) begin
            flag_next = cmp; // Evaluated only when enabled [RULE4] [RULE5]
        end
        hit        = load && enable && brake_en && cmp; // [RULE1] [RULE15]
        brake_next = brake_reg;
        if (hit) begin
            brake_next = 1'b1; // Brake wins over a same-cycle run request
        end else if (run_set) begin
            brake_next = 1'b0;
        end
    end

    // Flag and brake registers
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_reg  <= 1'b0;
            brake_reg <= 1'b0;
        end else begin
            flag_reg  <= flag_next;
            brake_reg <= brake_next;
        end
    end

    assign flag  = flag_reg;
    assign brake = brake_reg;

    AST_CMP_DISABLED: assert property (@(posedge clk) disable iff (rst)
        !enable |=> $stable(flag)) // [RULE4]
        else $error("Flag changed while comparator off");
endmodule

//--- hdl/adcrc_top.sv
// Purpose: Converter digital side: result, compare, fault brake, trigger delay, pin gating
// Assumes: Classic Wishbone slave, 8-bit registers in the low byte lane of a word
// Notes:   The analog converter sits outside: conv_start out, conv_done/conv_data in
// Behaviour
// [RULE1] Compare hit with brake enable asserts brake
// [RULE2] Brake clears PWM run; software re-sets it
// [RULE3] Polarity 0 means >=, 1 means <
// [RULE4] Comparator evaluates only while enabled
// [RULE5] Flag recomputed after every completed conversion; the code recomputes it only while comparator_en is set
// [RULE6] Delay is nine bits, bit 8 in control
// [RULE7] Wait delay in converter clocks, then convert
// [RULE8] Delay applies only to external triggers
// [RULE9] Software keeps delay steady while PWM runs
// [RULE10] Off bit forces pin digital input low
// [RULE11] Result readable as high byte, low nibble
// [RULE12] Writable twelve-bit threshold, high byte, nibble
// [RULE13] Done flag set; no start while set
// [RULE14] External triggers ignored while busy
// [RULE15] Flag and brake update with result write
module adcrc_top
    import adcrc_pkg::*;
#(
    parameter int ADC_DIV = ADCRC_ADC_DIV // System clocks per converter clock
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_trig,    // Detected external trigger, one-cycle pulse
    output logic             conv_start,  // Start the analog conversion, pulse
    input  wire logic        conv_done,   // Analog conversion finished, pulse
    input  wire logic [11:0] conv_data,   // Result with conv_done
    output logic             fault_brake, // PWM fault brake level
    output logic             pwm_run,     // PWM run bit
    output logic             irq,         // Level interrupt
    input  wire logic [7:0]  pin_in,      // Raw pin digital levels
    output logic      [7:0]  pin_din      // Gated pin digital levels
);
    // Bus state
    logic        ack_reg,  ack_next;
    logic [31:0] dat_reg,  dat_next;
    logic [7:0]  idx;          // Register index
    logic [7:0]  wdat;         // Write byte
    logic        wr;           // Write takes effect this edge
    // Software-visible registers
    logic [11:0] thr_reg,   thr_next;   // Compare threshold
    adcrc_ctl2_t ctl2_reg,  ctl2_next;  // Flag field unused here
    logic [7:0]  dly_reg,   dly_next;   // Delay bits 7..0
    logic [7:0]  aoff_reg,  aoff_next;  // Pin digital off
    logic        ext_reg,   ext_next;   // External trigger select
    logic        en_reg,    en_next;    // Converter enable
    logic        done_reg,  done_next;  // Conversion done flag
    logic        run_reg,   run_next;   // PWM run
    logic [1:0]  ien_reg,   ien_next;   // Interrupt enables
    logic [1:0]  ist_reg,   ist_next;   // Sticky status
    logic [11:0] res_reg,   res_next;   // Conversion result
    logic [7:0]  din_reg;               // Registered gated pins
    // Sequencer
    adcrc_state_t st_reg,   st_next;
    logic        start_reg, start_next;
    logic        dly_go, dly_fire, load, sw_start, run_set, hit, cmp_flag;
    // Converter clock divider
    logic [7:0]  div_reg,   div_next;
    logic        tick;

    assign idx  = wb_adr_i[9:2];
    assign wdat = wb_dat_i[7:0];
    // The master holds the request until it sees ack, so act on the ack edge
    assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
    assign sw_start = wr && (idx == ADCRC_IDX_CTL0) && wdat[ADCRC_CTL0_BUSY];
    assign run_set  = wr && (idx == ADCRC_IDX_PWM) && wdat[0];
    assign load     = (st_reg == ADCRC_CONV) && conv_done;

    // Converter clock enable divider
    always_comb begin
        tick     = (div_reg == 8'(ADC_DIV - 1));
        div_next = tick ? 8'h00 : div_reg + 8'h01;
    end

    // Bus answer: ack one cycle after request, read data captured with it
    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        dat_next = dat_reg;
        if (ack_next) begin
            dat_next = 32'h0000_0000; // Unmapped and write-only read zero
            case (idx)
                ADCRC_IDX_RES_LO:  dat_next[7:0] = {4'h0, res_reg[3:0]};   // [RULE11]
                ADCRC_IDX_RES_HI:  dat_next[7:0] = res_reg[11:4];          // [RULE11]
                ADCRC_IDX_CMP_LO:  dat_next[7:0] = {4'h0, thr_reg[3:0]};
                ADCRC_IDX_CMP_HI:  dat_next[7:0] = thr_reg[11:4];
                ADCRC_IDX_CTL0:    dat_next[7:0] = {done_reg, st_reg != ADCRC_IDLE, 6'h00};
                ADCRC_IDX_CTL1:    dat_next[7:0] = {6'h00, ext_reg, en_reg};
                ADCRC_IDX_CTL2:    dat_next[7:0] = {ctl2_reg.brake_on_compare_en,
                                                    ctl2_reg.compare_polarity,
                                                    ctl2_reg.comparator_en, cmp_flag,
                                                    3'h0, ctl2_reg.dly_bit8};
                ADCRC_IDX_DLY:     dat_next[7:0] = dly_reg;
                ADCRC_IDX_AOFF:    dat_next[7:0] = aoff_reg;
                ADCRC_IDX_PWM:     dat_next[7:0] = {7'h00, run_reg};
                ADCRC_IDX_IRQ_ST:  dat_next[7:0] = {6'h00, ist_reg};
                ADCRC_IDX_IRQ_EN:  dat_next[7:0] = {6'h00, ien_reg};
                default:           dat_next = 32'h0000_0000;
            endcase
        end
    end

    // Register writes and hardware updates
    always_comb begin
        thr_next  = thr_reg;
        ctl2_next = ctl2_reg;
        dly_next  = dly_reg;
        aoff_next = aoff_reg;
        ext_next  = ext_reg;
        en_next   = en_reg;
        done_next = done_reg;
        run_next  = run_reg;
        ien_next  = ien_reg;
        ist_next  = ist_reg;
        res_next  = res_reg;
        if (wr) begin
            case (idx)
                ADCRC_IDX_CMP_LO: thr_next[3:0]  = wdat[3:0]; // [RULE12]
                ADCRC_IDX_CMP_HI: thr_next[11:4] = wdat;      // [RULE12]
                ADCRC_IDX_CTL0:   if (!wdat[ADCRC_CTL0_DONE]) done_next = 1'b0;
                ADCRC_IDX_CTL1: begin
                    ext_next = wdat[ADCRC_CTL1_EXT];
                    en_next  = wdat[ADCRC_CTL1_EN];
                end
                ADCRC_IDX_CTL2: begin
                    ctl2_next.brake_on_compare_en = wdat[7];
                    ctl2_next.compare_polarity    = wdat[6];
                    ctl2_next.comparator_en       = wdat[5]; // Zero turns it off [RULE4]
                    ctl2_next.dly_bit8            = wdat[0]; // [RULE6]
                end
                ADCRC_IDX_DLY:    dly_next  = wdat;          // [RULE6]
                ADCRC_IDX_AOFF:   aoff_next = wdat;
                ADCRC_IDX_PWM:    run_next  = wdat[0];
                ADCRC_IDX_IRQ_CLR: ist_next = ist_reg & ~wdat[1:0];
                ADCRC_IDX_IRQ_EN: ien_next  = wdat[1:0];
                default: ;
            endcase
        end
        if (load) begin
            res_next  = conv_data;
            done_next = 1'b1; // Set wins over a same-cycle clear [RULE13]
        end
        if (hit) begin
            run_next = 1'b0; // Hardware stops PWM on compare brake [RULE2]
        end
        ist_next[ADCRC_EV_DONE]  = ist_next[ADCRC_EV_DONE] | load;
        ist_next[ADCRC_EV_BRAKE] = ist_next[ADCRC_EV_BRAKE] | hit;
    end

    // Conversion sequencer
    always_comb begin
        st_next    = st_reg;
        start_next = 1'b0;
        dly_go     = 1'b0;
        case (st_reg)
            ADCRC_IDLE: begin
                if (en_reg && !done_reg) begin // [RULE13]
                    if (sw_start) begin
                        start_next = 1'b1; // Software start skips the delay [RULE8]
                        st_next    = ADCRC_CONV;
                    end else if (ext_reg && ext_trig) begin
                        dly_go  = 1'b1; // [RULE8]
                        st_next = ADCRC_DELAY;
                    end
                end
            end
            ADCRC_DELAY: begin
                if (dly_fire) begin
                    start_next = 1'b1; // [RULE7]
                    st_next    = ADCRC_CONV;
                end
            end
            ADCRC_CONV: begin
                if (conv_done) begin
                    st_next = ADCRC_IDLE; // Triggers ignored until here [RULE14]
                end
            end
            default: st_next = ADCRC_IDLE;
        endcase
    end

    // All registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg   <= 1'b0;
            dat_reg   <= 32'h0000_0000;
            thr_reg   <= 12'h000;
            ctl2_reg  <= adcrc_ctl2_t'(ADCRC_RST_BYTE);
            dly_reg   <= ADCRC_RST_BYTE;
            aoff_reg  <= ADCRC_RST_BYTE;
            ext_reg   <= 1'b0;
            en_reg    <= 1'b0;
            done_reg  <= 1'b0;
            run_reg   <= 1'b0;
            ien_reg   <= 2'h0;
            ist_reg   <= 2'h0;
            res_reg   <= 12'h000;
            st_reg    <= ADCRC_IDLE;
            start_reg <= 1'b0;
            div_reg   <= 8'h00;
            din_reg   <= ADCRC_RST_BYTE;
        end else begin
            ack_reg   <= ack_next;
            dat_reg   <= dat_next;
            thr_reg   <= thr_next;
            ctl2_reg  <= ctl2_next;
            dly_reg   <= dly_next;
            aoff_reg  <= aoff_next;
            ext_reg   <= ext_next;
            en_reg    <= en_next;
            done_reg  <= done_next;
            run_reg   <= run_next;
            ien_reg   <= ien_next;
            ist_reg   <= ist_next;
            res_reg   <= res_next;
            st_reg    <= st_next;
            start_reg <= start_next;
            div_reg   <= div_next;
            din_reg   <= pin_in & ~aoff_reg; // Disabled pins read zero [RULE10]
        end
    end

    // Delay counter; software must not change it while a PWM trigger runs [RULE9]
    adcrc_delay #(.W(ADCRC_DLY_W)) u_delay (
        .clk   (clk),
        .rst   (rst),
        .go    (dly_go),
        .tick  (tick),
        .count ({ctl2_reg.dly_bit8, dly_reg}), // [RULE6]
        .fire  (dly_fire)
    );

    // Comparator and brake latch
    adcrc_compare #(.W(ADCRC_RES_W)) u_cmp (
        .clk       (clk),
        .rst       (rst),
        .load      (load),
        .result    (conv_data),
        .threshold (thr_reg),
        .polarity  (ctl2_reg.compare_polarity),
        .enable    (ctl2_reg.comparator_en),
        .brake_en  (ctl2_reg.brake_on_compare_en),
        .run_set   (run_set),
        .hit       (hit),
        .flag      (cmp_flag),
        .brake     (fault_brake)
    );

    assign wb_ack_o   = ack_reg;
    assign wb_dat_o   = dat_reg;
    assign conv_start = start_reg;
    assign pwm_run    = run_reg;
    assign pin_din    = din_reg;
    assign irq        = |(ist_reg & ien_reg);

    AST_BRAKE_SET: assert property (@(posedge clk) disable iff (rst)
        (load && ctl2_reg.comparator_en && ctl2_reg.brake_on_compare_en
         && (ctl2_reg.compare_polarity ? conv_data < thr_reg : conv_data >= thr_reg))
        |=> fault_brake && cmp_flag) // [RULE1]
        else $error("Compare hit did not brake");
    AST_RUN_CLEAR: assert property (@(posedge clk) disable iff (rst)
        hit |=> !pwm_run) // [RULE2]
        else $error("PWM run not cleared by brake");
    AST_POLARITY: assert property (@(posedge clk) disable iff (rst)
        (load && ctl2_reg.comparator_en) |=>
        cmp_flag == ($past(ctl2_reg.compare_polarity) ? ($past(conv_data) < $past(thr_reg))
                                           : ($past(conv_data) >= $past(thr_reg)))) // [RULE3]
        else $error("Compare flag wrong for polarity");
    AST_RESULT: assert property (@(posedge clk) disable iff (rst)
        load |=> res_reg == $past(conv_data) && done_reg) // [RULE15]
        else $error("Result not stored with done flag");
    AST_NO_START_DONE: assert property (@(posedge clk) disable iff (rst)
        done_reg |=> !start_reg || $past(st_reg) == ADCRC_DELAY) // [RULE13]
        else $error("Start while done flag set");
    AST_EXT_IGNORED: assert property (@(posedge clk) disable iff (rst)
        (st_reg != ADCRC_IDLE && ext_trig) |-> !dly_go) // [RULE14]
        else $error("External trigger taken while busy");
    AST_SW_NO_DELAY: assert property (@(posedge clk) disable iff (rst)
        (st_reg == ADCRC_IDLE && sw_start && en_reg && !done_reg) |=> start_reg) // [RULE8]
        else $error("Software start delayed");
    AST_DELAY_START: assert property (@(posedge clk) disable iff (rst)
        (st_reg == ADCRC_DELAY && dly_fire) |=> start_reg && st_reg == ADCRC_CONV) // [RULE7]
        else $error("Delay end did not start conversion");
    AST_PIN_OFF: assert property (@(posedge clk) disable iff (rst)
        ##1 (pin_din & $past(aoff_reg)) == 8'h00) // [RULE10]
        else $error("Disabled pin read nonzero");
    AST_BUS_ACK: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held two cycles");

    COV_SW_CONV: cover property (@(posedge clk) disable iff (rst) sw_start ##[1:50] load);
    COV_EXT_DELAY: cover property (@(posedge clk) disable iff (rst)
        dly_go ##[2:200] dly_fire);
    COV_BRAKE: cover property (@(posedge clk) disable iff (rst) hit ##[1:50] run_set);
endmodule

//--- verif/adcrc_conv_model.sv
// Purpose: Analog converter stand-in that answers each start pulse
// Assumes: One start at a time, a fixed conversion latency
// Notes:   Data churns outside the done cycle, so a stale read shows up
module adcrc_conv_model
#(
    parameter int LAT = 5 // Clocks from start to done
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        conv_start,
    input  wire logic [11:0] value,
    output logic             conv_done = 1'b0,
    output logic      [11:0] conv_data = 12'h000
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0; // Clocks left in the conversion
    // Count down from start, hand the value over with one done pulse
    always @(posedge clk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (rst) cnt <= 0;
        else if (conv_start) cnt <= LAT;
        else if (cnt > 0) cnt <= cnt - 1;
        if (cnt == 1) begin
            conv_done <= 1'b1;
            conv_data <= value;
        end
    end
endmodule

//--- verif/adcrc_bench.sv
// Purpose: Self-checking bench for the result, compare and delay block
// Assumes: A monitor checks each read against the oldest queued note
// Notes:   Converter clock of 4 system clocks keeps the 257 delay short
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t: got %h exp %h", $time, a, b); end end
module adcrc_bench
    import adcrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ext_trig = 0;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [7:0]  pin_in = 8'h00;
    logic [11:0] cval = 12'h000, th;
    wire  [31:0] wb_dat_o;
    wire  [11:0] conv_data;
    wire  [7:0]  pin_din;
    wire         wb_ack_o, conv_start, conv_done, fault_brake, pwm_run, irq;
    int          failures = 0, total_checks = 0, n;
    logic [31:0] seed = 32'h0a27_b904;
    logic [8:0]  d9;
    logic        pol, hit;
    logic [7:0]  exp_q[$], exp_v;
    logic [7:0]  rv[5] = '{ADCRC_IDX_RES_LO, ADCRC_IDX_CMP_HI, ADCRC_IDX_DLY,
                           ADCRC_IDX_AOFF, 8'h00};
    adcrc_top #(.ADC_DIV(4)) dut_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .ext_trig, .conv_start,
        .conv_done, .conv_data, .fault_brake, .pwm_run, .irq, .pin_in, .pin_din);
    adcrc_conv_model #(.LAT(5)) model_u (.clk, .rst, .conv_start, .value(cval),
        .conv_done, .conv_data);
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // One classic cycle, held until ack, then one idle cycle
    task automatic bus(input logic [7:0] ix, input logic we, input logic [7:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {ix, 2'b00};
        wb_dat_i <= {24'h00_0000, d};
        do begin @(posedge clk); k++; end while (wb_ack_o !== 1'b1 && k < 50);
        `CHK(k < 50, 1'b1)
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] ix, input logic [7:0] e);
        exp_q.push_back(e);
        bus(ix, 1'b0, 8'h00);
    endtask
    // Bounded wait for the converter to finish
    task automatic wdone();
        n = 0;
        while (conv_done !== 1'b1 && n < 20) begin @(posedge clk); n++; end
        `CHK(n < 20, 1'b1)
        @(posedge clk);
    endtask
    task automatic conv();
        bus(ADCRC_IDX_CTL0, 1'b1, 8'h00);
        bus(ADCRC_IDX_CTL0, 1'b1, 8'h40);
        wdone();
    endtask
    // Each read answer is taken at its ack edge
    always @(posedge clk) if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
        if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
        else begin
            exp_v = exp_q.pop_front();
            `CHK(wb_dat_o, {24'h00_0000, exp_v})
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rv[i]) rd(rv[i], 8'h00);
        $display("test reset done");
        seed = lfsr(seed);
        th = seed[11:0] | 12'h010;
        bus(ADCRC_IDX_CMP_HI, 1'b1, th[11:4]);
        bus(ADCRC_IDX_CMP_LO, 1'b1, {4'h0, th[3:0]});
        rd(ADCRC_IDX_CMP_HI, th[11:4]);
        rd(ADCRC_IDX_CMP_LO, {4'h0, th[3:0]});
        bus(ADCRC_IDX_CTL1, 1'b1, 8'h01);
        bus(ADCRC_IDX_IRQ_EN, 1'b1, 8'h01);
        // Equal result under both polarities, one-below result under polarity 1
        for (int i = 0; i < 3; i++) begin
            pol = (i != 0);
            hit = (i != 2);
            cval = (i == 1) ? th - 12'h001 : th;
            bus(ADCRC_IDX_PWM, 1'b1, 8'h01);
            bus(ADCRC_IDX_CTL2, 1'b1, {1'b1, pol, 1'b1, 5'h00});
            conv();
            `CHK(fault_brake, hit)
            `CHK(pwm_run, ~hit)
            `CHK(irq, 1'b1)
            rd(ADCRC_IDX_CTL2, {1'b1, pol, 1'b1, hit, 4'h0});
            rd(ADCRC_IDX_PWM, {7'h00, ~hit});
            rd(ADCRC_IDX_RES_HI, cval[11:4]);
            rd(ADCRC_IDX_RES_LO, {4'h0, cval[3:0]});
        end
        bus(ADCRC_IDX_IRQ_CLR, 1'b1, 8'h03);
        `CHK(irq, 1'b0)
        // Disabled comparator keeps its old flag
        cval = th - 12'h001;
        bus(ADCRC_IDX_CTL2, 1'b1, 8'hC0);
        conv();
        rd(ADCRC_IDX_CTL2, 8'hC0);
        `CHK(fault_brake, 1'b0)
        bus(ADCRC_IDX_CTL0, 1'b1, 8'hC0);
        rd(ADCRC_IDX_CTL0, 8'h80);
        $display("test compare done");
        bus(ADCRC_IDX_PWM, 1'b1, 8'h00);
        bus(ADCRC_IDX_CTL1, 1'b1, 8'h03);
        for (int i = 0; i < 3; i++) begin
            d9 = (i == 0) ? 9'h000 : (i == 1) ? 9'h003 : 9'h101;
            bus(ADCRC_IDX_DLY, 1'b1, d9[7:0]);
            bus(ADCRC_IDX_CTL2, 1'b1, {7'h00, d9[8]});
            bus(ADCRC_IDX_CTL0, 1'b1, 8'h00);
            ext_trig <= 1'b1;
            @(posedge clk);
            ext_trig <= 1'b0;
            n = 0;
            while (conv_start !== 1'b1 && n < 2000) begin
                @(posedge clk);
                n++;
                ext_trig <= (n == 50);
            end
            `CHK(n + 1 >= int'(d9) * 4 && n <= int'(d9) * 4 + 2, 1'b1)
            wdone();
        end
        conv();
        $display("test delay done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            bus(ADCRC_IDX_AOFF, 1'b1, seed[15:8]);
            pin_in <= seed[7:0];
            repeat (3) @(posedge clk);
            `CHK(pin_din, seed[7:0] & ~seed[15:8])
        end
        $display("test pins done");
        tally_and_finish();
    end
endmodule
